// file: rtl/mpp_port.sv
`timescale 1ns/1ps
// Contract
// - each pin is an input when its direction bit is 0 and an output when 1; directions reset to 0.
// - an input pin with input code 000 is copied into its bit of the input value field.
// - pin 0 as input with code 001 drives output enable select bit 0.
// - pin 1 as input with code 001 drives output enable select bit 1.
// - pin 2 as input with code 001 drives the manual reference select.
// - every input code resets to 001.
// - an output pin with output code 000 drives its output value bit; output values reset to 0.
// - pin 0 as output with code 001 shows the holdover flag.
// - pin 1 as output with code 001 shows the loss of signal flag of reference 1.
// - pin 2 as output with code 001 shows the loss of signal flag of reference 0.
// - pin 3 as output with code 001 shows the loss of lock flag.
// - every output code resets to 000, with codes 010 to 111 reserved.
// - software writes zero to reserved bits, whose read value is not defined.
// - the input value bits are read only at offset 0x20c.
// - each code is split over three registers, one bit per pin, high code bit lowest address.
module mpp_port
  import mpp_pkg::*;
(
  input  wire logic              clk_i,                     // register clock, 40 MHz
  input  wire logic              rst_i,                     // async reset, active high
  input  wire logic [MPP_AW-1:0] reg_addr_i,                // register byte offset
  input  wire logic              reg_wr_i,                  // write strobe, one cycle
  input  wire logic              reg_rd_i,                  // read strobe, one cycle
  input  wire logic [MPP_DW-1:0] reg_wdata_i,               // write data
  output logic      [MPP_DW-1:0] reg_rdata_o,               // read data, cycle after strobe
  input  wire logic [3:0]        gpio_i,                    // pin levels
  output logic      [3:0]        gpio_o,                    // pin drive values
  output logic      [3:0]        gpio_oe_o,                 // high while driving the pin
  input  wire logic              holdover_i,                // pll holdover flag
  input  wire logic              ref1_los_i,                // loss of signal, reference 1
  input  wire logic              ref0_los_i,                // loss of signal, reference 0
  input  wire logic              lock_loss_i,               // pll loss of lock flag
  output logic      [1:0]        output_enable_select_o,    // pin-driven enable select
  output logic                   manual_reference_select_o  // pin-driven reference select
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // rebuild one pin's code from the three bit planes
  function automatic logic [2:0] code_of(input logic [3:0] b2,
                                         input logic [3:0] b1,
                                         input logic [3:0] b0,
                                         input int         n);
    code_of = {b2[n], b1[n], b0[n]};
  endfunction : code_of

  // ****************************************************************
  // register file
  // ****************************************************************
  mpp_cfg_if cfg ();

  mpp_regs u_regs (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wr_i    (reg_wr_i),
    .reg_wdata_i (reg_wdata_i),
    .cfg         (cfg.regs)
  );

  // ****************************************************************
  // per-pin function decode
  // ****************************************************************
  logic [3:0] in_val_q;
  logic [3:0] status;
  logic [2:0] in_fn  [4];
  logic [2:0] out_fn [4];
  logic [3:0] plain_d;
  logic [3:0] alt_in;
  logic [3:0] drive_d;
  logic [3:0] pin_d;

  // status flags indexed by the pin that can show them
  assign status[ST_HOLDOVER]  = holdover_i;
  assign status[ST_REF1_LOS]  = ref1_los_i;
  assign status[ST_REF0_LOS]  = ref0_los_i;
  assign status[ST_LOCK_LOSS] = lock_loss_i;

  // reserved codes select nothing: the pin reads 0 or drives 0
  for (genvar n = 0; n < MPP_PINS; n++) begin : g_pin
    assign in_fn[n]   = code_of(cfg.in_b2, cfg.in_b1, cfg.in_b0, n);
    assign out_fn[n]  = code_of(cfg.out_b2, cfg.out_b1, cfg.out_b0, n);
    assign plain_d[n] = !cfg.dir[n] && (in_fn[n] == FN_PLAIN) && gpio_i[n];
    assign alt_in[n]  = !cfg.dir[n] && (in_fn[n] == FN_ALT) && gpio_i[n];
    assign drive_d[n] = (out_fn[n] == FN_PLAIN) ? cfg.out_val[n] :
                        (out_fn[n] == FN_ALT)   ? status[n] : 1'b0;
    assign pin_d[n]   = cfg.dir[n] && drive_d[n];
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // reserved upper bits and unmapped offsets read as zero
  logic [3:0] rd_nib;
  assign rd_nib = (reg_addr_i == OFS_DIR)     ? cfg.dir     :
                  (reg_addr_i == OFS_IN_B2)   ? cfg.in_b2   :
                  (reg_addr_i == OFS_IN_B1)   ? cfg.in_b1   :
                  (reg_addr_i == OFS_IN_B0)   ? cfg.in_b0   :
                  (reg_addr_i == OFS_OUT_B2)  ? cfg.out_b2  :
                  (reg_addr_i == OFS_OUT_B1)  ? cfg.out_b1  :
                  (reg_addr_i == OFS_OUT_B0)  ? cfg.out_b0  :
                  (reg_addr_i == OFS_OUT_VAL) ? cfg.out_val :
                  (reg_addr_i == OFS_IN_VAL)  ? in_val_q    : 4'h0;

  // read data holds between strobes so a slow reader sees it stable
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= {RSVD_HI, rd_nib};
    end
  end

  // ****************************************************************
  // input side
  // ****************************************************************
  // a pin not in plain input mode reads 0, never a stale level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_val_q <= 4'h0;
    end else begin
      in_val_q <= plain_d;
    end
  end

  // internal controls; pin 3 has no alternate input
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      output_enable_select_o    <= 2'h0;
      manual_reference_select_o <= 1'b0;
    end else begin
      output_enable_select_o[0] <= alt_in[0];
      output_enable_select_o[1] <= alt_in[1];
      manual_reference_select_o <= alt_in[2];
    end
  end

  // ****************************************************************
  // output side
  // ****************************************************************
  // data and enable registered together so they change on one edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gpio_o    <= 4'h0;
      gpio_oe_o <= 4'h0;
    end else begin
      gpio_o    <= pin_d;
      gpio_oe_o <= cfg.dir;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_dir_oe;
    gpio_oe_o == $past(cfg.dir);
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("pin enable does not follow direction");

  property p_rst_vals;
    $past(rst_i) |-> (cfg.dir == 4'h0) && (cfg.in_b0 == 4'hf) && (cfg.in_b1 == 4'h0)
                     && (cfg.in_b2 == 4'h0) && (cfg.out_val == 4'h0);
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("wrong value after reset");

  property p_rst_out_codes;
    $past(rst_i) |-> ({cfg.out_b2, cfg.out_b1, cfg.out_b0} == 12'h000) && (gpio_oe_o == 4'h0);
  endproperty
  a_rst_out_codes: assert property (p_rst_out_codes)
    else $error("output codes not cleared by reset");

  property p_plain_in;
    !cfg.dir[1] && (in_fn[1] == FN_PLAIN) |=> in_val_q[1] == $past(gpio_i[1]);
  endproperty
  a_plain_in: assert property (p_plain_in)
    else $error("plain input level not captured");

  property p_osel0;
    !cfg.dir[0] && (in_fn[0] == FN_ALT) |=> output_enable_select_o[0] == $past(gpio_i[0]);
  endproperty
  a_osel0: assert property (p_osel0)
    else $error("enable select bit 0 wrong");

  property p_osel1;
    !cfg.dir[1] && (in_fn[1] == FN_ALT) |=> output_enable_select_o[1] == $past(gpio_i[1]);
  endproperty
  a_osel1: assert property (p_osel1)
    else $error("enable select bit 1 wrong");

  property p_manual_reference_select;
    !cfg.dir[2] && (in_fn[2] == FN_ALT) |=> manual_reference_select_o == $past(gpio_i[2]);
  endproperty
  a_manual_reference_select: assert property (p_manual_reference_select)
    else $error("manual reference select wrong");

  property p_gpo;
    cfg.dir[3] && (out_fn[3] == FN_PLAIN) |=> gpio_oe_o[3] && (gpio_o[3] == $past(cfg.out_val[3]));
  endproperty
  a_gpo: assert property (p_gpo)
    else $error("output value not driven");

  property p_hold;
    cfg.dir[0] && (out_fn[0] == FN_ALT) |=> gpio_o[0] == $past(holdover_i);
  endproperty
  a_hold: assert property (p_hold)
    else $error("holdover flag not shown");

  property p_los1;
    cfg.dir[1] && (out_fn[1] == FN_ALT) |=> gpio_o[1] == $past(ref1_los_i);
  endproperty
  a_los1: assert property (p_los1)
    else $error("reference 1 loss flag not shown");

  property p_los0;
    cfg.dir[2] && (out_fn[2] == FN_ALT) |=> gpio_o[2] == $past(ref0_los_i);
  endproperty
  a_los0: assert property (p_los0)
    else $error("reference 0 loss flag not shown");

  property p_lol;
    cfg.dir[3] && (out_fn[3] == FN_ALT) |=> gpio_o[3] == $past(lock_loss_i);
  endproperty
  a_lol: assert property (p_lol)
    else $error("loss of lock flag not shown");

  property p_in_nodrive;
    !gpio_oe_o[2] |-> !gpio_o[2];
  endproperty
  a_in_nodrive: assert property (p_in_nodrive)
    else $error("input pin has drive data");

  property p_rd_inval;
    reg_rd_i && (reg_addr_i == OFS_IN_VAL) |=> reg_rdata_o == {4'h0, $past(in_val_q)};
  endproperty
  a_rd_inval: assert property (p_rd_inval)
    else $error("input value readback wrong");

  property p_plane_wr;
    reg_wr_i && (reg_addr_i == OFS_IN_B2) |=> cfg.in_b2 == $past(reg_wdata_i[3:0]);
  endproperty
  a_plane_wr: assert property (p_plane_wr)
    else $error("code plane write lost");

  property p_rsvd_rd;
    reg_rd_i |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd)
    else $error("reserved bits read nonzero");

  // every pin at once, not only the one above
  property p_nodrive_all;
    (gpio_o & ~gpio_oe_o) == 4'h0;
  endproperty
  a_nodrive_all: assert property (p_nodrive_all)
    else $error("undriven pin has drive data");

  property p_rsvd_out;
    cfg.dir[2] && (out_fn[2] != FN_PLAIN) && (out_fn[2] != FN_ALT) |=> !gpio_o[2];
  endproperty
  a_rsvd_out: assert property (p_rsvd_out)
    else $error("reserved output code drives the pin");

  property p_dir_wr;
    reg_wr_i && (reg_addr_i == OFS_DIR) |=> cfg.dir == $past(reg_wdata_i[3:0]);
  endproperty
  a_dir_wr: assert property (p_dir_wr)
    else $error("direction write lost");

  property p_in_off;
    cfg.dir[0] |=> !in_val_q[0];
  endproperty
  a_in_off: assert property (p_in_off)
    else $error("output pin shows in input value");

  property p_output_enable_select_off;
    cfg.dir[0] || (in_fn[0] != FN_ALT) |=> !output_enable_select_o[0];
  endproperty
  a_output_enable_select_off: assert property (p_output_enable_select_off)
    else $error("enable select bit 0 set while not selected");

endmodule : mpp_port

// file: rtl/mpp_pkg.sv
package mpp_pkg;

  // ****************************************************************
  // register map, byte offsets on the register port
  // ****************************************************************
  localparam int         MPP_AW         = 10;
  localparam int         MPP_DW         = 8;
  localparam int         MPP_PINS       = 4;
  localparam logic [9:0] OFS_DIR        = 10'h030;
  localparam logic [9:0] OFS_IN_B2      = 10'h031;
  localparam logic [9:0] OFS_IN_B1      = 10'h032;
  localparam logic [9:0] OFS_IN_B0      = 10'h033;
  localparam logic [9:0] OFS_OUT_B2     = 10'h034;
  localparam logic [9:0] OFS_OUT_B1     = 10'h035;
  localparam logic [9:0] OFS_OUT_B0     = 10'h036;
  localparam logic [9:0] OFS_RSVD       = 10'h037;
  localparam logic [9:0] OFS_OUT_VAL    = 10'h038;
  localparam logic [9:0] OFS_IN_VAL     = 10'h20c;

  // ****************************************************************
  // reset values, one bit per pin in each plane
  // ****************************************************************
  localparam logic [3:0] RST_DIR        = 4'h0;
  localparam logic [3:0] RST_IN_B2      = 4'h0;
  localparam logic [3:0] RST_IN_B1      = 4'h0;
  localparam logic [3:0] RST_IN_B0      = 4'hf;
  localparam logic [3:0] RST_OUT_B2     = 4'h0;
  localparam logic [3:0] RST_OUT_B1     = 4'h0;
  localparam logic [3:0] RST_OUT_B0     = 4'h0;
  localparam logic [3:0] RST_OUT_VAL    = 4'h0;
  localparam logic [3:0] RSVD_HI        = 4'h0;

  // ****************************************************************
  // function codes and status flag positions
  // ****************************************************************
  localparam logic [2:0] FN_PLAIN       = 3'h0;
  localparam logic [2:0] FN_ALT         = 3'h1;
  localparam int         ST_HOLDOVER    = 0;
  localparam int         ST_REF1_LOS    = 1;
  localparam int         ST_REF0_LOS    = 2;
  localparam int         ST_LOCK_LOSS   = 3;

endpackage : mpp_pkg

// file: rtl/mpp_cfg_if.sv
`timescale 1ns/1ps
// configuration planes from the register file to the pin logic
interface mpp_cfg_if;
  logic [3:0] dir;
  logic [3:0] in_b2;
  logic [3:0] in_b1;
  logic [3:0] in_b0;
  logic [3:0] out_b2;
  logic [3:0] out_b1;
  logic [3:0] out_b0;
  logic [3:0] out_val;

  modport regs (output dir, in_b2, in_b1, in_b0, out_b2, out_b1, out_b0, out_val);
  modport core (input  dir, in_b2, in_b1, in_b0, out_b2, out_b1, out_b0, out_val);
endinterface : mpp_cfg_if

// file: rtl/mpp_regs.sv
`timescale 1ns/1ps
module mpp_regs
  import mpp_pkg::*;
(
  input  wire logic              clk_i,       // register clock
  input  wire logic              rst_i,       // async reset, active high
  input  wire logic [MPP_AW-1:0] reg_addr_i,  // byte offset
  input  wire logic              reg_wr_i,    // write strobe
  input  wire logic [MPP_DW-1:0] reg_wdata_i, // write data
  mpp_cfg_if.regs                cfg          // planes to pin logic
);

  // ****************************************************************
  // write decode
  // ****************************************************************
  // only the low nibble is stored; upper bits are reserved
  wire logic [3:0] wnib     = reg_wdata_i[3:0];
  wire logic       we_dir   = reg_wr_i && (reg_addr_i == OFS_DIR);
  wire logic       we_in2   = reg_wr_i && (reg_addr_i == OFS_IN_B2);
  wire logic       we_in1   = reg_wr_i && (reg_addr_i == OFS_IN_B1);
  wire logic       we_in0   = reg_wr_i && (reg_addr_i == OFS_IN_B0);
  wire logic       we_out2  = reg_wr_i && (reg_addr_i == OFS_OUT_B2);
  wire logic       we_out1  = reg_wr_i && (reg_addr_i == OFS_OUT_B1);
  wire logic       we_out0  = reg_wr_i && (reg_addr_i == OFS_OUT_B0);
  wire logic       we_outv  = reg_wr_i && (reg_addr_i == OFS_OUT_VAL);

  // ****************************************************************
  // storage
  // ****************************************************************
  // one code bit per register, pin n in bit n
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg.dir     <= RST_DIR;
      cfg.in_b2   <= RST_IN_B2;
      cfg.in_b1   <= RST_IN_B1;
      cfg.in_b0   <= RST_IN_B0;
      cfg.out_b2  <= RST_OUT_B2;
      cfg.out_b1  <= RST_OUT_B1;
      cfg.out_b0  <= RST_OUT_B0;
      cfg.out_val <= RST_OUT_VAL;
    end else begin
      if (we_dir)  cfg.dir     <= wnib;
      if (we_in2)  cfg.in_b2   <= wnib;
      if (we_in1)  cfg.in_b1   <= wnib;
      if (we_in0)  cfg.in_b0   <= wnib;
      if (we_out2) cfg.out_b2  <= wnib;
      if (we_out1) cfg.out_b1  <= wnib;
      if (we_out0) cfg.out_b0  <= wnib;
      if (we_outv) cfg.out_val <= wnib;
    end
  end

endmodule : mpp_regs

// file: bench/mpp_board.sv
`timescale 1ns/1ps
// ****************************************************************
// board logic sitting on the four general-purpose pins
// ****************************************************************
module mpp_board (
  input  wire logic [3:0] gpio_o_i,  // device drive values
  input  wire logic [3:0] gpio_oe_i, // device drive enables
  input  wire logic [3:0] drv_val_i, // board drive values
  input  wire logic [3:0] drv_en_i,  // board drive enables
  output logic      [3:0] level_o    // resolved pin level
);
  // pins nobody drives sit on board pull-downs, so no stale level survives a release
  assign level_o = (gpio_oe_i & gpio_o_i) | (~gpio_oe_i & drv_en_i & drv_val_i);
endmodule : mpp_board

// file: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import mpp_pkg::*;
  // ****************************************************************
  // stimulus and observation signals
  // ****************************************************************
  localparam logic [9:0] MAP [0:8] = '{OFS_DIR, OFS_IN_B2, OFS_IN_B1, OFS_IN_B0, OFS_OUT_B2,
                                       OFS_OUT_B1, OFS_OUT_B0, OFS_RSVD, OFS_OUT_VAL};
  logic       clk;
  logic       rst;
  logic       wr;
  logic       rd;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [3:0] pin_lvl;
  logic [3:0] pin_output_values;
  logic [3:0] gpoe;
  logic [3:0] drv_val;
  logic [3:0] drv_en;
  logic [3:0] st;
  logic [1:0] output_enable_select;
  logic       manual_reference_select;
  int         failures;
  int         total_checks;

  mpp_port mpp_port_i (.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .gpio_i(pin_lvl), .gpio_o(pin_output_values),
    .gpio_oe_o(gpoe), .holdover_i(st[0]), .ref1_los_i(st[1]), .ref0_los_i(st[2]),
    .lock_loss_i(st[3]), .output_enable_select_o(output_enable_select), .manual_reference_select_o(manual_reference_select));
  mpp_board mpp_board_i (.gpio_o_i(pin_output_values), .gpio_oe_i(gpoe), .drv_val_i(drv_val),
    .drv_en_i(drv_en), .level_o(pin_lvl));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // software keeps reserved bits 7:4 at zero on every write
  task automatic wreg(input logic [9:0] a, input logic [3:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= {4'h0, d};
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  // pins answer one cycle after config, so three edges leave margin
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [7:0] d;
    logic [3:0] exp [0:8];
    exp = '{4'h0, 4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
    for (int i = 0; i < 9; i++) begin
      if (i == 7) continue;
      rreg(MAP[i], d);
      chk(d, {4'h0, exp[i]});
    end
    chk({4'h0, gpoe}, 8'h00);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_roundtrip;
    logic [7:0] d;
    for (int i = 0; i < 9; i++) if (i != 7) wreg(MAP[i], 4'(i * 5 + 1));
    for (int i = 0; i < 9; i++) begin
      if (i == 7) continue;
      rreg(MAP[i], d);
      chk(d, {4'h0, 4'(i * 5 + 1)});
    end
    do_reset();
    rreg(OFS_DIR, d);
    chk(d, 8'h00);
    rreg(OFS_IN_B0, d);
    chk(d, 8'h0f);
    rreg(OFS_OUT_VAL, d);
    chk(d, 8'h00);
    $display("test register roundtrip done");
  endtask : t_roundtrip

  task automatic t_plain_in;
    logic [7:0] d;
    logic [3:0] p;
    wreg(OFS_IN_B0, 4'h0);
    drv_en <= 4'hf;
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 4'h5 : (i == 1) ? 4'ha : 4'hf;
      drv_val <= p;
      settle();
      rreg(OFS_IN_VAL, d);
      chk(d, {4'h0, p});
      chk({5'h0, manual_reference_select, output_enable_select}, 8'h00);
    end
    wreg(OFS_IN_VAL, 4'h0);
    rreg(OFS_IN_VAL, d);
    chk(d, 8'h0f);
    $display("test plain inputs done");
  endtask : t_plain_in

  task automatic t_alt_in;
    logic [7:0] d;
    logic [3:0] p;
    wreg(OFS_IN_B0, 4'h7);
    for (int i = 0; i < 2; i++) begin
      p = i ? 4'ha : 4'h5;
      drv_val <= p;
      settle();
      chk({6'h0, output_enable_select}, {6'h0, p[1:0]});
      chk({7'h0, manual_reference_select}, {7'h0, p[2]});
      rreg(OFS_IN_VAL, d);
      chk(d, {4'h0, p[3], 3'h0});
    end
    $display("test pin functions done");
  endtask : t_alt_in

  task automatic t_outputs;
    drv_en <= 4'h0;
    wreg(OFS_DIR, 4'hf);
    for (int i = 0; i < 2; i++) begin
      wreg(OFS_OUT_VAL, i ? 4'h5 : 4'ha);
      settle();
      chk({gpoe, pin_output_values}, {4'hf, i ? 4'h5 : 4'ha});
      chk({5'h0, manual_reference_select, output_enable_select}, 8'h00);
    end
    wreg(OFS_OUT_B0, 4'hf);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      st <= 4'(3 * i + 1);
      settle();
      chk({4'h0, pin_output_values}, {4'h0, 4'(3 * i + 1)});
    end
    wreg(OFS_OUT_B0, 4'h2);
    wreg(OFS_OUT_B1, 4'h4);
    wreg(OFS_OUT_VAL, 4'h9);
    st <= 4'hf;
    settle();
    chk({4'h0, pin_output_values}, 8'h0b);
    wreg(OFS_DIR, 4'h5);
    settle();
    chk({4'h0, gpoe}, 8'h05);
    chk({4'h0, pin_output_values}, 8'h01);
    $display("test outputs done");
  endtask : t_outputs

  // ****************************************************************
  // clock, reset, sequence, watchdog and verdict
  // ****************************************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst, wr, rd, addr, wdata, drv_val, drv_en, st} = {1'b1, 32'h0};
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_roundtrip();
    t_plain_in();
    t_alt_in();
    t_outputs();
    print_verdict();
  end

  // the full sequence needs under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : tb
